// File: logic/scbs_regs.svh
// Constants for the serial configuration bitstream source
`ifndef SCBS_REGS_SVH
`define SCBS_REGS_SVH

// Core clock rate in Hz
`define SCBS_CLK_HZ 20000000
// Power-on delay in milliseconds, typical figure
`define SCBS_POR_MS 100
// Power-on delay in milliseconds, worst case
`define SCBS_POR_MAX_MS 200
// Core cycles per half period of the generated configuration clock
`define SCBS_MCLK_HALF 4
// Configuration clocks issued after the target reports done
`define SCBS_TAIL_CLOCKS 16
// Core cycles the output-enable line is held low on an error before an automatic restart
`define SCBS_ERR_HOLD 8
// Default stored bitstream length in bits
`define SCBS_DEPTH 64
// Default number of bits held by downstream cascaded devices
`define SCBS_CHAIN_EXTRA 0

`endif

// File: logic/scbs_pkg.sv
// Types shared by the serial configuration bitstream source
`default_nettype none
package scbs_pkg;

  typedef enum logic [2:0] {
    SCBS_POR,
    SCBS_RUN,
    SCBS_TAIL,
    SCBS_IDLE,
    SCBS_ERROR
  } scbs_state_t;

  // Pin levels that cross into the core clock domain together
  typedef struct packed {
    logic oe;
    logic cs_n;
    logic config_clock;
    logic master;
  } scbs_pins_t;

endpackage
`default_nettype wire

// File: logic/scbs_bit_store.sv
// Stored configuration bitstream, one bit per word, registered read
`default_nettype none
module scbs_bit_store #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Load port
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic i_wr_bit,
  // Read port
  input wire logic [AW-1:0] i_rd_addr,
  output logic o_rd_bit
);

  logic mem [DEPTH];

  always_ff @(posedge i_clk)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_bit;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_rd_bit <= 1'b0;
    end
    else
    begin
      o_rd_bit <= mem[i_rd_addr];
    end
  end

endmodule
`default_nettype wire

// File: logic/scbs_loader.sv
// Serial configuration bitstream source: counter, cascade, error check, clocking
`include "scbs_regs.svh"
`default_nettype none
module scbs_loader #(
  parameter int DEPTH = `SCBS_DEPTH,
  parameter int CHAIN_EXTRA = `SCBS_CHAIN_EXTRA,
  parameter int POR_CYCLES = `SCBS_CLK_HZ / 1000 * `SCBS_POR_MS,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // Mode strap and option
  input wire logic I_MASTER_MODE,
  input wire logic I_AUTO_RESTART,
  // Bitstream load port, core clock domain
  input wire logic I_LOAD_EN,
  input wire logic [AW-1:0] I_LOAD_ADDR,
  input wire logic I_LOAD_BIT,
  // Configuration link
  input wire logic I_CONFIG_CLOCK,
  input wire logic I_CHIP_SELECT_N,
  output logic O_CONFIG_CLOCK,
  output logic O_DATA,
  output logic O_DATA_EN,
  output logic O_CASCADE_OUT_N,
  // Output-enable line, shared with target status, open drain
  input wire logic I_OE,
  output logic O_OE,
  output logic O_OE_EN
);

  localparam int PCW = $clog2(POR_CYCLES + 1);

  scbs_pkg::scbs_state_t state;
  scbs_pkg::scbs_pins_t pin_meta;
  scbs_pkg::scbs_pins_t pin_sync;
  logic clk_prev;
  logic [AW-1:0] addr;
  logic sent;
  logic mclk;
  logic [7:0] mdiv;
  logic [PCW-1:0] por_cnt;
  logic [4:0] tail_cnt;
  logic [7:0] err_cnt;
  logic [15:0] extra_cnt;
  logic rd_bit;
  logic clk_run;
  logic mclk_rise;
  logic slave_rise;
  logic pin_rise;
  logic adv;
  logic clr;
  logic restart;
  logic early_done;
  logic late_done;
  logic master;
  logic oe;
  logic cs;

  // Two-stage synchronisers for the enable, chip select, clock and mode pins
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      clk_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= '{oe: I_OE, cs_n: I_CHIP_SELECT_N,
                    config_clock: I_CONFIG_CLOCK, master: I_MASTER_MODE};
      pin_sync <= pin_meta;
      clk_prev <= pin_sync.config_clock;
    end
  end

  assign master = pin_sync.master;
  assign oe = pin_sync.oe;
  assign cs = ~pin_sync.cs_n;
  assign slave_rise = pin_sync.config_clock & ~clk_prev;
  assign clk_run = master && (state == scbs_pkg::SCBS_RUN || state == scbs_pkg::SCBS_TAIL);
  assign mclk_rise = clk_run && !mclk && mdiv == 8'(`SCBS_MCLK_HALF - 1);
  // Count as the pin rises, so data enable outlives the target's sampling edge
  assign pin_rise = mclk && !O_CONFIG_CLOCK;
  // Edges only count with enable high, select low and data left
  assign adv = (master ? pin_rise : slave_rise) && oe && cs && !sent
               && state == scbs_pkg::SCBS_RUN;
  assign restart = state == scbs_pkg::SCBS_ERROR && I_AUTO_RESTART
                   && err_cnt == 8'(`SCBS_ERR_HOLD);
  // Our own low drive on the line must not look like a target reset
  assign clr = (!oe && state != scbs_pkg::SCBS_ERROR) || restart;
  // Done seen on chip select; checks only with the link out of reset
  assign early_done = master && oe && !cs && !sent;
  assign late_done = master && oe && cs && sent && mclk_rise
                     && extra_cnt == 16'(CHAIN_EXTRA);

  // Generated configuration clock, held low outside a frame
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST || !clk_run)
    begin
      mclk <= 1'b0;
      mdiv <= '0;
    end
    else if (mdiv == 8'(`SCBS_MCLK_HALF - 1))
    begin
      mclk <= ~mclk;
      mdiv <= '0;
    end
    else
    begin
      mdiv <= mdiv + 8'h01;
    end
  end

  // Address counter and exhaustion flag
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST || clr)
    begin
      addr <= '0;
      sent <= 1'b0;
    end
    else if (adv)
    begin
      if (addr == AW'(DEPTH - 1))
      begin
        sent <= 1'b1;
      end
      else
      begin
        addr <= addr + AW'(1);
      end
    end
  end

  // Extra clocks given to downstream devices after own data
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST || clr || !sent)
    begin
      extra_cnt <= '0;
    end
    else if (mclk_rise && cs && state == scbs_pkg::SCBS_RUN)
    begin
      extra_cnt <= extra_cnt + 16'h0001;
    end
  end

  // Sequencer
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      state <= scbs_pkg::SCBS_POR;
    end
    else if (state == scbs_pkg::SCBS_ERROR)
    begin
      if (restart)
      begin
        state <= scbs_pkg::SCBS_RUN;
      end
    end
    else if (!oe)
    begin
      if (state != scbs_pkg::SCBS_POR)
      begin
        state <= scbs_pkg::SCBS_RUN;
      end
    end
    else
    begin
      case (state)
        scbs_pkg::SCBS_POR:
        begin
          if (!master || por_cnt == PCW'(POR_CYCLES))
          begin
            state <= scbs_pkg::SCBS_RUN;
          end
        end
        scbs_pkg::SCBS_RUN:
        begin
          if (early_done || late_done)
          begin
            state <= scbs_pkg::SCBS_ERROR;
          end
          else if (master && sent && !cs)
          begin
            state <= scbs_pkg::SCBS_TAIL;
          end
        end
        scbs_pkg::SCBS_TAIL:
        begin
          if (mclk_rise && tail_cnt == 5'(`SCBS_TAIL_CLOCKS - 1))
          begin
            state <= scbs_pkg::SCBS_IDLE;
          end
        end
        scbs_pkg::SCBS_IDLE:
        begin
          state <= scbs_pkg::SCBS_IDLE;
        end
        default:
        begin
          state <= scbs_pkg::SCBS_POR;
        end
      endcase
    end
  end

  // Power-on, tail and error hold counters
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      por_cnt <= '0;
    end
    else if (state == scbs_pkg::SCBS_POR && por_cnt != PCW'(POR_CYCLES))
    begin
      por_cnt <= por_cnt + PCW'(1);
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST || state != scbs_pkg::SCBS_TAIL)
    begin
      tail_cnt <= '0;
    end
    else if (mclk_rise)
    begin
      tail_cnt <= tail_cnt + 5'h01;
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST || state != scbs_pkg::SCBS_ERROR)
    begin
      err_cnt <= '0;
    end
    else if (err_cnt != 8'(`SCBS_ERR_HOLD))
    begin
      err_cnt <= err_cnt + 8'h01;
    end
  end

  scbs_bit_store #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_store (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_wr_en(I_LOAD_EN),
    .i_wr_addr(I_LOAD_ADDR),
    .i_wr_bit(I_LOAD_BIT),
    .i_rd_addr(addr),
    .o_rd_bit(rd_bit)
  );

  // Pin drivers, all registered
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      O_CONFIG_CLOCK <= 1'b0;
      O_DATA <= 1'b0;
      O_DATA_EN <= 1'b0;
      O_CASCADE_OUT_N <= 1'b1;
      O_OE <= 1'b0;
      O_OE_EN <= 1'b0;
    end
    else
    begin
      O_CONFIG_CLOCK <= mclk;
      O_DATA <= rd_bit;
      O_DATA_EN <= oe && cs && !sent && !clr
                   && state == scbs_pkg::SCBS_RUN;
      O_CASCADE_OUT_N <= !sent || clr;
      O_OE <= 1'b0;
      O_OE_EN <= state == scbs_pkg::SCBS_ERROR && !restart;
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  data_float_sent_a: assert property (sent |=> !O_DATA_EN)
    else $error("data driven after own data sent");
  data_float_cs_a: assert property (!cs |=> !O_DATA_EN)
    else $error("data driven with chip select high");
  addr_step_a: assert property (adv && !sent && !clr && addr != AW'(DEPTH - 1)
    |=> addr == $past(addr) + AW'(1))
    else $error("address did not step on clock edge");
  count_gate_a: assert property (!adv && !clr |=> $stable(addr) && $stable(sent))
    else $error("counter moved without a qualified edge");
  oe_reset_a: assert property (!oe && state != scbs_pkg::SCBS_ERROR
    |=> addr == '0 && !sent && !O_DATA_EN)
    else $error("low enable did not reset counter");
  oe_data_a: assert property (!oe |=> !O_DATA_EN)
    else $error("data driven with enable low");
  cascade_low_a: assert property (sent && !clr |=> !O_CASCADE_OUT_N)
    else $error("cascade output not low after last bit");
  por_quiet_a: assert property (state == scbs_pkg::SCBS_POR && master
    |-> por_cnt <= PCW'(POR_CYCLES) && !mclk)
    else $error("clock ran during power-on delay");
  slave_no_err_a: assert property (!master && state != scbs_pkg::SCBS_ERROR
    |=> state != scbs_pkg::SCBS_ERROR)
    else $error("error raised in slave-clock mode");
  early_err_a: assert property (state == scbs_pkg::SCBS_RUN && oe && early_done
    |=> state == scbs_pkg::SCBS_ERROR ##1 O_OE_EN)
    else $error("early done not flagged");
  err_drive_a: assert property (state == scbs_pkg::SCBS_ERROR && !restart
    |=> O_OE_EN && !O_OE)
    else $error("error did not pull enable line low");
  tail_len_a: assert property (state == scbs_pkg::SCBS_TAIL
    |-> tail_cnt < 5'(`SCBS_TAIL_CLOCKS))
    else $error("tail ran past sixteen clocks");

  full_load_c: cover property (state == scbs_pkg::SCBS_TAIL ##1 state == scbs_pkg::SCBS_IDLE);
  error_c: cover property (state == scbs_pkg::SCBS_RUN ##1 state == scbs_pkg::SCBS_ERROR);
  restart_c: cover property (restart);
  cascade_c: cover property (!master && sent);

endmodule
`default_nettype wire

// File: testbench/scbs_target_model.sv
// Model of the target device that receives the serial stream
`default_nettype none
module scbs_target_model (
  // Link from the loader
  input wire logic i_run,
  input wire logic i_master,
  input wire logic i_mclk,
  input wire logic i_data,
  input wire logic i_data_en,
  input wire logic i_line,
  input wire logic [31:0] i_done_at,
  // Back to the loader
  output logic o_clk,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rx[$];
  int got = 0;
  int rises = 0;
  wire logic clk_eff = i_master ? i_mclk : o_clk;
  // Offset keeps link edges away from core clock edges
  initial
  begin
    o_clk = 1'b0;
    #7;
    forever #200 o_clk = i_run ? ~o_clk : 1'b0;
  end
  assign o_done = got >= int'(i_done_at);
  // Status line low restarts reception
  always @(posedge clk_eff or negedge i_line)
  begin
    if (!i_line)
    begin
      rx.delete();
      got = 0;
      rises = 0;
    end
    else
    begin
      rises++;
      if (i_data_en && !o_done)
      begin
        rx.push_back(i_data);
        got++;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/test_scbs_loader.sv
// Testbench for the serial configuration bitstream source
`default_nettype none
module test_scbs_loader;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int D = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic master = 1'b0;
  logic autor = 1'b0;
  logic ld_en = 1'b0;
  logic ld_bit = 1'b0;
  logic [2:0] ld_addr = 3'h0;
  logic run = 1'b0;
  logic cs_drv = 1'b1;
  logic crc_bad = 1'b0;
  logic [31:0] done_at = 32'h8;
  logic bits[$];
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  wire logic mclk, dat, dat_en, casc_n, oe_en, oe_lvl, tclk, tdone;
  // Pulled-up line, low when either side pulls it
  wire logic line = ~((oe_en & ~oe_lvl) | crc_bad);
  wire logic cs_pin = master ? tdone : cs_drv;
  // Chip select of a following device in the chain
  wire logic next_cs_n = casc_n;
  always #25 clk = ~clk;
  scbs_loader #(.DEPTH(D), .CHAIN_EXTRA(0), .POR_CYCLES(20)) dut_u (
    .I_REF_CLK(clk), .I_RST(rst), .I_MASTER_MODE(master), .I_AUTO_RESTART(autor),
    .I_LOAD_EN(ld_en), .I_LOAD_ADDR(ld_addr), .I_LOAD_BIT(ld_bit),
    .I_CONFIG_CLOCK(tclk), .I_CHIP_SELECT_N(cs_pin), .O_CONFIG_CLOCK(mclk), .O_DATA(dat),
    .O_DATA_EN(dat_en), .O_CASCADE_OUT_N(casc_n), .I_OE(line), .O_OE(oe_lvl),
    .O_OE_EN(oe_en));
  scbs_target_model tgt_u (.i_run(run), .i_master(master), .i_mclk(mclk), .i_data(dat),
    .i_data_en(dat_en), .i_line(line), .i_done_at(done_at), .o_clk(tclk), .o_done(tdone));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Reset, clear the target, then load fresh random bits
  task automatic start(input logic m, input logic ar, input logic [31:0] da);
    rst = 1'b1;
    crc_bad = 1'b1;
    master = m;
    autor = ar;
    done_at = da;
    run = 1'b0;
    cs_drv = 1'b1;
    cyc(11);
    crc_bad = 1'b0;
    cyc(1);
    rst = 1'b0;
    bits.delete();
    for (int a = 0; a < D; a++)
    begin
      bits.push_back(1'($urandom_range(1, 0)));
      ld_en = 1'b1;
      ld_addr = a[2:0];
      ld_bit = bits[a];
      cyc(1);
    end
    ld_en = 1'b0;
    cyc(2);
  endtask
  task automatic pulse(input int n);
    run = 1'b1;
    repeat (n) @(posedge tclk);
    #5;
    run = 1'b0;
    cyc(10);
  endtask
  task automatic wait_sig(input int which, input logic v, input int lim);
    while (lim > 0 && (which ? oe_en : casc_n) !== v)
    begin
      cyc(1);
      lim--;
    end
  endtask
  task automatic stream();
    for (int i = 0; i < D; i++)
      check(tgt_u.rx[i], bits[i]);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_total++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(84));
    // Slave clocking, selection and line reset
    start(1'b0, 1'b0, 32'd99);
    check(dat_en, 1'b0);
    check(casc_n, 1'b1);
    cs_drv = 1'b0;
    cyc(4);
    check(dat_en, 1'b1);
    check(dat, bits[0]);
    pulse(3);
    cs_drv = 1'b1;
    cyc(6);
    pulse(3);
    check(dat_en, 1'b0);
    check(oe_en, 1'b0);
    check(tgt_u.got, 3);
    crc_bad = 1'b1;
    cyc(4);
    crc_bad = 1'b0;
    cs_drv = 1'b0;
    cyc(6);
    check(dat, bits[0]);
    run = 1'b1;
    wait_sig(0, 1'b0, 200);
    run = 1'b0;
    cyc(10);
    check(casc_n, 1'b0);
    check(next_cs_n, 1'b0);
    check(dat_en, 1'b0);
    stream();
    // Master clocking with a clean finish
    start(1'b1, 1'b0, D);
    cyc(4);
    check(tgt_u.rises, 0);
    cyc(320);
    check(tgt_u.rises, D + 16);
    check(mclk, 1'b0);
    check(oe_en, 1'b0);
    stream();
    // Done too early, then a clean retry by itself
    start(1'b1, 1'b1, D / 2);
    wait_sig(1, 1'b1, 300);
    check(oe_en, 1'b1);
    done_at = D;
    wait_sig(1, 1'b0, 40);
    check(oe_en, 1'b0);
    cyc(320);
    check(tgt_u.rises, D + 16);
    stream();
    // Done never comes
    start(1'b1, 1'b0, 32'd99);
    cyc(300);
    check(oe_en, 1'b1);
    check(oe_lvl, 1'b0);
    check(line, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
